// ===== design/ggtp_pkg.sv
// Purpose: constants for the gauge two-wire target port
// Assumes: clk at 100 MHz, bus pins sampled through two flops
// Notes: Operation
// Operation
// - support read, incremental, quick read, writes
// - answer only target address 1010101
// - first byte 0xaa write, 0xab read
// - quick read returns byte at pointer
// - pointer advances on every acked byte; code advances it on acked data bytes only, not address or command
// - multi-byte writes fill consecutive locations
// - nack data written to read-only location
// - nack command byte above 0x6b
// - release both lines after 2 s low
// - sleep if line still held after release; code sleeps on every timeout, waking once both lines are high
// - device may reset on watchdog expiry
// - device may stretch, master honours it
// - idle modes stretch on wake, max 100 us
// - active modes stretch for flow, max 4 ms
package ggtp_pkg;
   localparam logic [6:0]  GGTP_TARGET_ADDR = 7'h55;
   localparam logic [7:0]  GGTP_CMD_MAX     = 8'h6b;
   localparam logic [7:0]  GGTP_RO_LO       = 8'h02;
   localparam logic [7:0]  GGTP_RO_HI       = 8'h3d;
   localparam logic [7:0]  GGTP_RW_ALL_LO   = 8'h3e;
   localparam logic [7:0]  GGTP_RO2_LO      = 8'h62;
   localparam int          GGTP_CLK_HZ      = 100_000_000;
   localparam int          GGTP_TIMEOUT_MS  = 2000;
   localparam int          GGTP_WAKE_US     = 100;
   localparam int          GGTP_FLOW_MS     = 4;
   localparam int          GGTP_TIMEOUT_CYC =
      GGTP_TIMEOUT_MS * (GGTP_CLK_HZ / 1000);
   localparam int          GGTP_WAKE_CYC    =
      GGTP_WAKE_US * (GGTP_CLK_HZ / 1_000_000);
   localparam int          GGTP_FLOW_CYC    =
      GGTP_FLOW_MS * (GGTP_CLK_HZ / 1000);
   localparam logic [2:0]  GGTP_BIT_LAST    = 3'h7;

   typedef enum logic [2:0] {
      GGTP_IDLE  = 3'b000,
      GGTP_ADDR  = 3'b001,
      GGTP_ACK   = 3'b011,
      GGTP_WDATA = 3'b010,
      GGTP_RDATA = 3'b110,
      GGTP_RACK  = 3'b111,
      GGTP_SLEEP = 3'b101
   } ggtp_state_e;

   // locations 0x02..0x3d and 0x62 upward are read-only
   function automatic logic ggtp_read_only(input logic [7:0] a);
      ggtp_read_only = (a >= GGTP_RO_LO && a <= GGTP_RO_HI) ||
                       (a >= GGTP_RO2_LO);
   endfunction : ggtp_read_only
endpackage : ggtp_pkg

// ===== design/ggtp_sync.sv
// Purpose: two-flop synchroniser for the bus pins
// Assumes: inputs asynchronous to clk
// Notes: first stage read only by second
`timescale 1ns/10ps
module ggtp_sync (
   input  wire logic clk,
   input  wire logic reset_n,
   input  wire logic d,
   output logic      q
);
   logic meta_reg;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         meta_reg <= 1'b1;
         q        <= 1'b1;
      end else begin
         meta_reg <= d;
         q        <= meta_reg;
      end
   end
endmodule : ggtp_sync

// ===== design/ggtp_target.sv
// Purpose: two-wire target engine with auto-increment pointer
// Assumes: command memory 128 bytes, user side writes it
// Notes: clock stretch requested by stretch_req or idle_mode from the gauge core
`timescale 1ns/10ps
module ggtp_target
   import ggtp_pkg::*;
#(
   parameter int TIMEOUT_CYC = GGTP_TIMEOUT_CYC
) (
   input  wire logic       clk,
   input  wire logic       reset_n,
   input  wire logic       scl_in,
   output logic            scl_out,
   output logic            scl_oe,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe,
   input  wire logic       idle_mode,
   input  wire logic       stretch_req,
   input  wire logic       core_wr,
   input  wire logic [6:0] core_addr,
   input  wire logic [7:0] core_data,
   output logic            wr_strobe,
   output logic [6:0]      wr_loc,
   output logic [7:0]      wr_byte,
   output logic [7:0]      ptr,
   output logic            asleep
);
   logic scl_s, sda_s, scl_d, sda_d;
   ggtp_sync u_scl (.clk(clk), .reset_n(reset_n), .d(scl_in), .q(scl_s));
   ggtp_sync u_sda (.clk(clk), .reset_n(reset_n), .d(sda_in), .q(sda_s));

   logic [7:0]  mem [0:127];
   ggtp_state_e state_reg;
   logic [7:0]  shift_reg;
   logic [2:0]  bit_reg;
   logic        rw_reg, cmd_seen_reg, ack_ok_reg, sda_low_reg;
   logic        byte_full_reg;
   logic [31:0] low_cnt_reg, str_cnt_reg;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         scl_d <= scl_s;
         sda_d <= sda_s;
      end
   end

   wire scl_rise = scl_s & ~scl_d;
   wire scl_fall = ~scl_s & scl_d;
   wire start_c  = scl_s & scl_d & sda_d & ~sda_s;
   wire stop_c   = scl_s & scl_d & ~sda_d & sda_s;
   wire timeout  = (low_cnt_reg >= TIMEOUT_CYC - 1);
   wire [7:0] rx = {shift_reg[6:0], sda_s};

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n)
         low_cnt_reg <= '0;
      else if ((scl_s && sda_s) || timeout)
         low_cnt_reg <= '0;
      else
         low_cnt_reg <= low_cnt_reg + 32'h1;
   end

   wire str_max = idle_mode ? (str_cnt_reg >= GGTP_WAKE_CYC - 1)
                            : (str_cnt_reg >= GGTP_FLOW_CYC - 1);
   logic stretching, woke_reg;
   // wake stretch once per packet, flow stretch on any fall
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         str_cnt_reg <= '0;
         stretching  <= 1'b0;
         woke_reg    <= 1'b0;
      end else if (state_reg == GGTP_IDLE || state_reg == GGTP_SLEEP) begin
         str_cnt_reg <= '0;
         stretching  <= 1'b0;
         woke_reg    <= 1'b0;
      end else if (scl_fall &&
                   ((idle_mode && !woke_reg) || stretch_req)) begin
         str_cnt_reg <= '0;
         stretching  <= 1'b1;
         woke_reg    <= woke_reg | idle_mode;
      end else if (stretching) begin
         str_cnt_reg <= str_cnt_reg + 32'h1;
         if (str_max || (!idle_mode && !stretch_req))
            stretching <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (core_wr)
         mem[core_addr] <= core_data;
      else if (wr_strobe)
         mem[wr_loc] <= wr_byte;
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_reg    <= GGTP_IDLE;
         shift_reg    <= 8'h00;
         bit_reg      <= 3'h0;
         rw_reg       <= 1'b0;
         cmd_seen_reg <= 1'b0;
         ack_ok_reg   <= 1'b0;
         sda_low_reg  <= 1'b0;
         byte_full_reg <= 1'b0;
         ptr          <= 8'h00;
         wr_strobe    <= 1'b0;
         wr_loc       <= 7'h00;
         wr_byte      <= 8'h00;
         asleep       <= 1'b0;
      end else begin
         wr_strobe <= 1'b0;
         if (timeout) begin
            sda_low_reg <= 1'b0;
            state_reg   <= GGTP_SLEEP;
            asleep      <= 1'b1;
         end else if (state_reg == GGTP_SLEEP) begin
            if (scl_s && sda_s) begin
               state_reg <= GGTP_IDLE;
               asleep    <= 1'b0;
            end
         end else if (stop_c) begin
            sda_low_reg <= 1'b0;
            state_reg   <= GGTP_IDLE;
         end else if (start_c) begin
            sda_low_reg  <= 1'b0;
            byte_full_reg <= 1'b0;
            bit_reg      <= 3'h0;
            cmd_seen_reg <= 1'b0;
            state_reg    <= GGTP_ADDR;
         end else begin
            case (state_reg)
               GGTP_ADDR, GGTP_WDATA: begin
                  if (scl_rise) begin
                     shift_reg <= rx;
                     bit_reg   <= bit_reg + 3'h1;
                     if (bit_reg == GGTP_BIT_LAST)
                        byte_full_reg <= 1'b1;
                  end
                  // ack slot follows the eighth bit, whatever its value
                  if (scl_fall && byte_full_reg) begin
                     byte_full_reg <= 1'b0;
                     state_reg     <= GGTP_ACK;
                     if (state_reg == GGTP_ADDR) begin
                        ack_ok_reg <= (shift_reg[7:1] == GGTP_TARGET_ADDR);
                        rw_reg     <= shift_reg[0];
                     end else if (!cmd_seen_reg) begin
                        ack_ok_reg   <= (shift_reg <= GGTP_CMD_MAX);
                        cmd_seen_reg <= 1'b1;
                        if (shift_reg <= GGTP_CMD_MAX)
                           ptr <= shift_reg;
                     end else begin
                        ack_ok_reg <= !ggtp_read_only(ptr);
                        if (!ggtp_read_only(ptr)) begin
                           wr_strobe <= 1'b1;
                           wr_loc    <= ptr[6:0];
                           wr_byte   <= shift_reg;
                           ptr       <= ptr + 8'h1;
                        end
                     end
                     sda_low_reg <= 1'b0;
                  end
               end
               GGTP_ACK: begin
                  sda_low_reg <= ack_ok_reg;
                  if (scl_fall) begin
                     sda_low_reg <= 1'b0;
                     bit_reg     <= 3'h0;
                     shift_reg   <= 8'h00;
                     if (!ack_ok_reg)
                        state_reg <= GGTP_IDLE;
                     else if (rw_reg) begin
                        shift_reg   <= mem[ptr[6:0]];
                        sda_low_reg <= ~mem[ptr[6:0]][7];
                        state_reg   <= GGTP_RDATA;
                     end else
                        state_reg <= GGTP_WDATA;
                  end
               end
               GGTP_RDATA: begin
                  if (scl_fall) begin
                     if (bit_reg == GGTP_BIT_LAST) begin
                        sda_low_reg <= 1'b0;
                        state_reg   <= GGTP_RACK;
                     end else begin
                        sda_low_reg <= ~shift_reg[6];
                        shift_reg   <= {shift_reg[6:0], 1'b0};
                        bit_reg     <= bit_reg + 3'h1;
                     end
                  end
               end
               GGTP_RACK: begin
                  if (scl_rise) begin
                     if (!sda_s) begin
                        ptr       <= ptr + 8'h1;
                        ack_ok_reg <= 1'b1;
                     end else
                        ack_ok_reg <= 1'b0;
                  end
                  if (scl_fall) begin
                     bit_reg <= 3'h0;
                     if (ack_ok_reg) begin
                        shift_reg   <= mem[ptr[6:0]];
                        sda_low_reg <= ~mem[ptr[6:0]][7];
                        state_reg   <= GGTP_RDATA;
                     end else
                        state_reg <= GGTP_IDLE;
                  end
               end
               default: state_reg <= GGTP_IDLE;
            endcase
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sda_out <= 1'b0;
         sda_oe  <= 1'b0;
         scl_out <= 1'b0;
         scl_oe  <= 1'b0;
      end else begin
         sda_out <= 1'b0;
         scl_out <= 1'b0;
         sda_oe  <= sda_low_reg && !timeout && state_reg != GGTP_SLEEP;
         scl_oe  <= stretching && !timeout && state_reg != GGTP_SLEEP;
      end
   end

   property p_timeout_release;
      @(posedge clk) disable iff (!reset_n)
      timeout |=> ##1 (!sda_oe && !scl_oe);
   endproperty
   a_timeout_release: assert property (p_timeout_release)
      else $error("lines still driven after timeout");

   property p_sleep;
      @(posedge clk) disable iff (!reset_n)
      timeout |=> asleep;
   endproperty
   a_sleep: assert property (p_sleep)
      else $error("engine not asleep after timeout");

   property p_wake_bound;
      @(posedge clk) disable iff (!reset_n)
      (idle_mode && stretching) |-> (str_cnt_reg < GGTP_WAKE_CYC);
   endproperty
   a_wake_bound: assert property (p_wake_bound)
      else $error("wake stretch too long");

   property p_flow_bound;
      @(posedge clk) disable iff (!reset_n)
      (!idle_mode && stretching) |-> (str_cnt_reg < GGTP_FLOW_CYC);
   endproperty
   a_flow_bound: assert property (p_flow_bound)
      else $error("flow stretch too long");

   property p_ro_guard;
      @(posedge clk) disable iff (!reset_n)
      wr_strobe |-> !ggtp_read_only({1'b0, wr_loc});
   endproperty
   a_ro_guard: assert property (p_ro_guard)
      else $error("write to read-only location");

   property p_wr_inc;
      @(posedge clk) disable iff (!reset_n)
      wr_strobe |-> (ptr == {1'b0, wr_loc} + 8'h1);
   endproperty
   a_wr_inc: assert property (p_wr_inc)
      else $error("pointer did not advance");
endmodule : ggtp_target

// ===== verif/ggtp_host.sv
// Purpose: two-wire bus master model for the target port
// Assumes: lines pulled up, oe high pulls a line low
// Notes: quarter bit is 4 clk, bit period 160 ns
`timescale 1ns/10ps
module ggtp_host (
   input  wire logic clk,
   input  wire logic scl,
   input  wire logic sda,
   output logic      scl_oe,
   output logic      sda_oe,
   output logic      hang
);
   initial begin
      scl_oe = 1'b0;
      sda_oe = 1'b0;
      hang   = 1'b0;
   end
   task automatic q;
      repeat (4) @(negedge clk);
   endtask : q
   task automatic rise;
      int n;
      n = 0;
      scl_oe = 1'b0;
      while (!scl && n < 12000) begin
         @(negedge clk);
         n++;
      end
      if (!scl) hang = 1'b1;
      q();
   endtask : rise
   task automatic bit_io(input logic b, output logic s);
      q();
      sda_oe = !b;
      q();
      rise();
      s = sda;
      q();
      scl_oe = 1'b1;
   endtask : bit_io
   task automatic start;
      if (scl_oe) begin
         q();
         sda_oe = 1'b0;
         q();
         rise();
      end
      sda_oe = 1'b1;
      q();
      scl_oe = 1'b1;
   endtask : start
   task automatic stop;
      q();
      sda_oe = 1'b1;
      q();
      rise();
      sda_oe = 1'b0;
      repeat (6600) @(negedge clk);
   endtask : stop
   task automatic byte_io(input logic [7:0] d, input logic m,
                          output logic [7:0] r, output logic k);
      for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
      bit_io(m, k);
   endtask : byte_io
   task automatic hold_low(input int n);
      scl_oe = 1'b1;
      repeat (n) @(negedge clk);
      scl_oe = 1'b0;
      repeat (20) @(negedge clk);
   endtask : hold_low
endmodule : ggtp_host

// ===== verif/ggtp_target_bench.sv
// Purpose: self-checking bench for the two-wire target engine
// Assumes: timeout shortened to 2000 cycles
// Notes: host model owns the bus timing
`timescale 1ns/10ps
module ggtp_target_bench;
   import ggtp_pkg::*;
   localparam int TO_CYC = 2000;
   logic        clk, reset_n, idle_mode, stretch_req, core_wr;
   logic        scl_oe, sda_oe, scl_out, sda_out, wr_strobe;
   logic        asleep, h_scl, h_sda, hang, scl, sda, k;
   logic [6:0]  core_addr, wr_loc;
   logic [7:0]  core_data, wr_byte, ptr, r;
   logic [14:0] wq[$];
   int          n_mismatch, compares, run, maxrun;
   assign scl = !(h_scl | scl_oe);
   assign sda = !(h_sda | sda_oe);
   ggtp_target #(.TIMEOUT_CYC(TO_CYC)) uut (.clk, .reset_n,
      .scl_in(scl), .scl_out, .scl_oe, .sda_in(sda), .sda_out, .sda_oe,
      .idle_mode, .stretch_req, .core_wr, .core_addr, .core_data,
      .wr_strobe, .wr_loc, .wr_byte, .ptr, .asleep);
   ggtp_host host (.clk, .scl, .sda, .scl_oe(h_scl), .sda_oe(h_sda),
      .hang);
   always #5 clk = ~clk;
   always @(posedge clk) begin
      if (wr_strobe) wq.push_back({wr_loc, wr_byte});
      run = scl_oe ? run + 1 : 0;
      if (run > maxrun) maxrun = run;
   end
   task automatic check(input string nm, input logic [15:0] s, e);
      compares++;
      if (s !== e) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", nm, e, s);
      end
   endtask : check
   task automatic wb(input logic [7:0] d, input logic ek);
      host.byte_io(d, 1'b1, r, k);
      check("ack", !k, ek);
   endtask : wb
   task automatic final_report;
      $display("compares %0d n_mismatch %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : final_report
   task automatic t_write;
      host.start();
      wb(8'haa, 1'b1);
      wb(8'h3e, 1'b1);
      wb(8'h11, 1'b1);
      wb(8'h22, 1'b1);
      host.stop();
      check("wr0", wq.pop_front(), {7'h3e, 8'h11});
      check("wr1", wq.pop_front(), {7'h3f, 8'h22});
      check("ptr", ptr, 8'h40);
      $display("write done");
   endtask : t_write
   // incremental subcommand only at slow clock, unused
   // two standard commands, no result awaited
   task automatic t_subcmd;
      host.start();
      wb(8'haa, 1'b1);
      wb(8'h00, 1'b1);
      wb(8'h3c, 1'b1);
      host.stop();
      host.start();
      wb(8'haa, 1'b1);
      wb(8'h01, 1'b1);
      wb(8'h00, 1'b1);
      host.stop();
      check("sub0", wq.pop_front(), {7'h00, 8'h3c});
      check("sub1", wq.pop_front(), {7'h01, 8'h00});
      check("ptr", ptr, 8'h02);
      $display("subcommand done");
   endtask : t_subcmd
   task automatic t_refuse;
      host.start();
      wb(8'ha8, 1'b0);
      host.stop();
      host.start();
      wb(8'haa, 1'b1);
      wb(8'h6c, 1'b0);
      host.stop();
      host.start();
      wb(8'haa, 1'b1);
      wb(8'h6b, 1'b1);
      wb(8'h55, 1'b0);
      host.stop();
      check("count", wq.size(), 16'h0);
      check("ptr", ptr, 8'h6b);
      $display("refuse done");
   endtask : t_refuse
   task automatic t_read;
      for (int i = 0; i < 2; i++) begin
         @(negedge clk);
         core_wr   = 1'b1;
         core_addr = 7'h10 + 7'(i);
         core_data = i ? 8'hc3 : 8'h5a;
      end
      @(negedge clk);
      core_wr = 1'b0;
      host.start();
      wb(8'haa, 1'b1);
      wb(8'h10, 1'b1);
      host.start();
      wb(8'hab, 1'b1);
      host.byte_io(8'hff, 1'b0, r, k);
      check("rd0", r, 8'h5a);
      host.byte_io(8'hff, 1'b1, r, k);
      check("rd1", r, 8'hc3);
      host.stop();
      check("ptr", ptr, 8'h11);
      host.start();
      wb(8'hab, 1'b1);
      host.byte_io(8'hff, 1'b1, r, k);
      host.stop();
      check("quick", r, 8'hc3);
      $display("read done");
   endtask : t_read
   task automatic t_stretch;
      idle_mode = 1'b1;
      maxrun    = 0;
      fork
         begin
            // core finishes waking after 400 cycles
            repeat (400) @(negedge clk);
            idle_mode = 1'b0;
         end
         begin
            host.start();
            wb(8'haa, 1'b1);
            host.stop();
         end
      join
      check("wake", maxrun inside {[1:GGTP_WAKE_CYC]}, 1'b1);
      check("wake_len", maxrun >= 300, 1'b1);
      maxrun = 0;
      fork
         begin
            stretch_req = 1'b1;
            repeat (300) @(negedge clk);
            stretch_req = 1'b0;
         end
         begin
            host.start();
            wb(8'haa, 1'b1);
            wb(8'h3e, 1'b1);
            wb(8'h01, 1'b1);
            host.stop();
         end
      join
      check("flow", maxrun > 0, 1'b1);
      check("wr", wq.pop_front(), {7'h3e, 8'h01});
      check("hang", hang, 1'b0);
      $display("stretch done");
   endtask : t_stretch
   task automatic t_timeout;
      fork
         host.hold_low(TO_CYC + 100);
         begin
            repeat (TO_CYC + 50) @(negedge clk);
            check("oe", {scl_oe, sda_oe}, 2'b00);
            check("sleep", asleep, 1'b1);
         end
      join
      check("wake", asleep, 1'b0);
      check("drv", {scl_out, sda_out}, 2'b00);
      host.start();
      wb(8'haa, 1'b1);
      wb(8'h3f, 1'b1);
      host.stop();
      check("ptr", ptr, 8'h3f);
      $display("timeout done");
   endtask : t_timeout
   initial begin
      clk         = 1'b0;
      reset_n     = 1'b0;
      idle_mode   = 1'b0;
      stretch_req = 1'b0;
      core_wr     = 1'b0;
      core_addr   = 7'h00;
      core_data   = 8'h00;
      repeat (8) @(negedge clk);
      reset_n = 1'b1;
      repeat (4) @(negedge clk);
      t_write();
      t_subcmd();
      t_refuse();
      t_read();
      t_stretch();
      t_timeout();
      final_report();
   end
   initial begin
      repeat (120000) @(posedge clk);
      n_mismatch++;
      final_report();
   end
endmodule : ggtp_target_bench
